// >>> shared/pmau_pkg.sv
package pmau_pkg;
   // ----------------------------------------
   // Widths and keys
   // ----------------------------------------
   localparam int          ADDR_W          = 15;
   localparam int          WORD_W          = 14;
   localparam logic [7:0]  KEY_FIRST       = 8'h55;
   localparam logic [7:0]  KEY_SECOND      = 8'hAA;
   localparam int          PGM_SEL_BIT     = 15;
   localparam logic [3:0]  KIND_NONE       = 4'h0;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int          CLK_HZ          = 40_000_000;
   localparam int          STALL_US        = 2000;
   localparam int          STALL_CYC       = (CLK_HZ / 1_000_000) * STALL_US;
   localparam int          FORCED_NOPS     = 2;
   localparam int          PGM_EXTRA_CYC   = 1;

   // Self-write operation kinds
   typedef enum logic [1:0] {
      PMAU_OP_ERASE,
      PMAU_OP_LOAD,
      PMAU_OP_WRITE,
      PMAU_OP_USERID
   } pmau_op_t;

   // Indirect access request from the core
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] pointer;
      logic [7:0]  wdata;
   } pmau_ind_req_t;

   // Unlock / control request from the core
   typedef struct packed {
      logic        key_wr;
      logic [7:0]  key_data;
      logic        init_set;
      pmau_op_t    op;
   } pmau_ctl_req_t;
endpackage

// >>> core/pmau_top.sv
`timescale 1ns/1ps
module pmau_top #(
   parameter int STALL_CYCLES = pmau_pkg::STALL_CYC
) (
   // Clock and reset
   input  wire logic                   MCLK,
   input  wire logic                   SYS_RST,
   // Indirect access from core
   input  wire pmau_pkg::pmau_ind_req_t IND_REQ,
   output logic                        IND_BUSY,
   output logic                        IND_DONE,
   output logic [7:0]                  IND_RDATA,
   // Program memory read port
   output logic                        PM_RD_EN,
   output logic [14:0]                 PM_RD_ADDR,
   input  wire logic [13:0]            PM_RD_DATA,
   // Data memory port
   output logic                        DM_EN,
   output logic                        DM_WE,
   output logic [11:0]                 DM_ADDR,
   output logic [7:0]                  DM_WDATA,
   input  wire logic [7:0]             DM_RDATA,
   // Unlock and control from core
   input  wire pmau_pkg::pmau_ctl_req_t CTL_REQ,
   // Program memory self-write engine
   output logic                        NVM_START,
   output logic [1:0]                  NVM_OP,
   // Core pipeline control
   output logic                        FORCE_NOP,
   output logic                        CORE_STALL,
   output logic                        WR_BUSY
);
   initial begin
      if (STALL_CYCLES < 1) $error("STALL_CYCLES must be at least 1");
      if (pmau_pkg::FORCED_NOPS < 1 || pmau_pkg::FORCED_NOPS > 3)
         $error("FORCED_NOPS must fit the two-bit slot counter");
      if (pmau_pkg::ADDR_W != 15) $error("Program address width must be 15");
      if (pmau_pkg::WORD_W != 14) $error("Program word width must be 14");
   end

   // ----------------------------------------
   // Pointer decode
   // ----------------------------------------
   // Top bit of the pointer picks program memory over data memory
   function automatic logic pgm_space(input logic [15:0] ptr);
      return ptr[pmau_pkg::PGM_SEL_BIT];
   endfunction

   // Data space covers the whole 12-bit register map
   function automatic logic [11:0] data_addr(input logic [15:0] ptr);
      return ptr[11:0];
   endfunction

   // Program space uses the fifteen bits below the select bit
   function automatic logic [14:0] pgm_addr(input logic [15:0] ptr);
      return ptr[14:0];
   endfunction

   // ----------------------------------------
   // Indirect access
   // ----------------------------------------
   typedef enum {PMAU_IND_IDLE, PMAU_IND_PGM} pmau_ind_st_t;
   pmau_ind_st_t ind_st_r;
   logic         is_pgm;

   // A write aimed at program space is acknowledged like a read
   // but reaches neither memory; only DM_WE can alter state
   assign is_pgm     = pgm_space(IND_REQ.pointer);
   assign PM_RD_EN   = IND_REQ.valid && is_pgm && !IND_REQ.write
                       && ind_st_r == PMAU_IND_IDLE;
   assign PM_RD_ADDR = pgm_addr(IND_REQ.pointer);
   assign DM_EN      = IND_REQ.valid && !is_pgm;
   assign DM_WE      = DM_EN && IND_REQ.write;
   assign DM_ADDR    = data_addr(IND_REQ.pointer);
   assign DM_WDATA   = IND_REQ.wdata;
   // Extra cycle for program reads and writes alike; writes there are dropped
   assign IND_BUSY   = IND_REQ.valid && is_pgm && ind_st_r == PMAU_IND_IDLE;

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ind_st_r <= PMAU_IND_IDLE;
      end else begin
         case (ind_st_r)
            PMAU_IND_IDLE: if (IND_BUSY) ind_st_r <= PMAU_IND_PGM;
            PMAU_IND_PGM:  ind_st_r <= PMAU_IND_IDLE;
            default:       ind_st_r <= PMAU_IND_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Program word capture
   // ----------------------------------------
   // The memory answers only while PM_RD_EN is high, in the first cycle;
   // the byte is held here so the extra cycle never sees a released port
   logic [7:0] pgm_byte_r;

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pgm_byte_r <= 8'h00;
      end else if (PM_RD_EN) begin
         pgm_byte_r <= PM_RD_DATA[7:0];
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         IND_DONE  <= 1'b0;
         IND_RDATA <= 8'h00;
      end else begin
         IND_DONE <= 1'b0;
         if (IND_REQ.valid && !is_pgm) begin
            IND_DONE <= 1'b1;
            if (!IND_REQ.write) IND_RDATA <= DM_RDATA;
         end else if (ind_st_r == PMAU_IND_PGM) begin
            IND_DONE <= 1'b1;
            // Write has no path to program memory at all
            if (!IND_REQ.write) IND_RDATA <= pgm_byte_r;
         end
      end
   end

   // ----------------------------------------
   // Unlock sequence
   // ----------------------------------------
   typedef enum {PMAU_UL_IDLE, PMAU_UL_GOT55, PMAU_UL_ARMED} pmau_ul_st_t;
   pmau_ul_st_t ul_st_r;

   // Any other key write, or any other key value, drops the arming
   // Idle cycles between keys keep the sequence alive, so firmware
   // must mask interrupts itself to keep stray key writes out
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ul_st_r <= PMAU_UL_IDLE;
      end else if (CTL_REQ.init_set) begin
         ul_st_r <= PMAU_UL_IDLE;
      end else if (CTL_REQ.key_wr) begin
         case (ul_st_r)
            PMAU_UL_IDLE:
               ul_st_r <= (CTL_REQ.key_data == pmau_pkg::KEY_FIRST)
                          ? PMAU_UL_GOT55 : PMAU_UL_IDLE;
            PMAU_UL_GOT55:
               ul_st_r <= (CTL_REQ.key_data == pmau_pkg::KEY_SECOND)
                          ? PMAU_UL_ARMED : PMAU_UL_IDLE;
            default: ul_st_r <= PMAU_UL_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Forced NOPs and stall
   // ----------------------------------------
   typedef enum {PMAU_WR_IDLE, PMAU_WR_NOP, PMAU_WR_STALL} pmau_wr_st_t;
   pmau_wr_st_t  wr_st_r;
   logic [1:0]   nop_cnt_r;
   logic [31:0]  stall_cnt_r;
   logic         accept;
   logic         long_op_r;

   // Counter is 32 bits wide; real stall counts sit far below that
   // Only an initiate while armed by both keys, with the engine idle, is honoured
   assign accept = CTL_REQ.init_set && ul_st_r == PMAU_UL_ARMED
                   && wr_st_r == PMAU_WR_IDLE;

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wr_st_r     <= PMAU_WR_IDLE;
         nop_cnt_r   <= 2'd0;
         stall_cnt_r <= 32'd0;
         long_op_r   <= 1'b0;
         NVM_START   <= 1'b0;
         NVM_OP      <= 2'd0;
      end else begin
         NVM_START <= 1'b0;
         case (wr_st_r)
            PMAU_WR_IDLE: if (accept) begin
               wr_st_r   <= PMAU_WR_NOP;
               // Loaded one short: the zero count is a slot as well
               nop_cnt_r <= 2'(pmau_pkg::FORCED_NOPS - 1);
               long_op_r <= CTL_REQ.op != pmau_pkg::PMAU_OP_LOAD;
               NVM_START <= 1'b1;
               NVM_OP    <= CTL_REQ.op;
            end
            PMAU_WR_NOP: if (nop_cnt_r != 2'd0) begin
               nop_cnt_r <= nop_cnt_r - 2'd1;
            end else if (long_op_r) begin
               wr_st_r     <= PMAU_WR_STALL;
               stall_cnt_r <= 32'(STALL_CYCLES - 1);
            end else begin
               wr_st_r <= PMAU_WR_IDLE;
            end
            PMAU_WR_STALL: if (stall_cnt_r == 32'd0) begin
               wr_st_r <= PMAU_WR_IDLE;
            end else begin
               stall_cnt_r <= stall_cnt_r - 32'd1;
            end
            default: wr_st_r <= PMAU_WR_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Core control outputs
   // ----------------------------------------
   // WR_BUSY spans both the forced slots and the stall, so the
   // core may poll it instead of counting cycles
   assign FORCE_NOP  = wr_st_r == PMAU_WR_NOP;
   assign CORE_STALL = wr_st_r == PMAU_WR_STALL;
   assign WR_BUSY    = wr_st_r != PMAU_WR_IDLE;
endmodule

// >>> test/pmau_props.sv
`timescale 1ns/1ps
module pmau_props #(parameter int STALL_CYCLES = 5) (
   // Clock and reset
   input wire logic                    MCLK, SYS_RST,
   // Indirect access
   input wire pmau_pkg::pmau_ind_req_t IND_REQ,
   input wire logic                    IND_BUSY, IND_DONE, PM_RD_EN, DM_EN, DM_WE,
   input wire logic [7:0]              IND_RDATA, DM_WDATA, DM_RDATA,
   input wire logic [14:0]             PM_RD_ADDR,
   input wire logic [13:0]             PM_RD_DATA,
   input wire logic [11:0]             DM_ADDR,
   // Self-write
   input wire pmau_pkg::pmau_ctl_req_t CTL_REQ,
   input wire logic                    NVM_START, FORCE_NOP, CORE_STALL, WR_BUSY,
   input wire logic [1:0]              NVM_OP
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   logic [1:0] key_r;
   int         stall_r;
   // Armed only after 55h then AAh with no other key write between
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) key_r <= 2'h0;
      else if (CTL_REQ.init_set) key_r <= 2'h0;
      else if (CTL_REQ.key_wr) key_r <= (CTL_REQ.key_data == pmau_pkg::KEY_FIRST) ? 2'h1 :
         (CTL_REQ.key_data == pmau_pkg::KEY_SECOND && key_r == 2'h1) ? 2'h2 : 2'h0;
   end
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) stall_r <= 0;
      else stall_r <= CORE_STALL ? stall_r + 1 : 0;
   end
   property p_sel; IND_BUSY && !IND_REQ.write
      |-> PM_RD_EN && PM_RD_ADDR == IND_REQ.pointer[14:0]; endproperty
   a_sel: assert property (p_sel) else $error("program read not routed");
   property p_low; IND_BUSY && !IND_REQ.write ##1 1 |=> IND_RDATA == $past(PM_RD_DATA[7:0], 2);
   endproperty
   a_low: assert property (p_low) else $error("program read data wrong");
   property p_nowr; IND_REQ.valid && IND_REQ.pointer[15] |-> !DM_WE; endproperty
   a_nowr: assert property (p_nowr) else $error("program write leaked");
   property p_slow; IND_BUSY |=> !IND_DONE ##1 IND_DONE; endproperty
   a_slow: assert property (p_slow) else $error("program access timing");
   property p_map; IND_REQ.valid && !IND_REQ.pointer[15] && !IND_DONE
      |-> DM_EN && DM_ADDR == IND_REQ.pointer[11:0] ##1 IND_DONE; endproperty
   a_map: assert property (p_map) else $error("data access wrong");
   property p_arm; CTL_REQ.init_set && key_r == 2'h2 && !WR_BUSY
      |=> NVM_START && NVM_OP == $past(CTL_REQ.op); endproperty
   a_arm: assert property (p_arm) else $error("unlocked request lost");
   property p_ref; CTL_REQ.init_set && key_r != 2'h2 |=> !NVM_START; endproperty
   a_ref: assert property (p_ref) else $error("locked request accepted");
   property p_nop; NVM_START |-> FORCE_NOP ##1 FORCE_NOP ##1 !FORCE_NOP; endproperty
   a_nop: assert property (p_nop) else $error("forced cycles wrong");
   property p_stall; NVM_START && NVM_OP != 2'h1 |-> ##2 CORE_STALL; endproperty
   a_stall: assert property (p_stall) else $error("no stall");
   property p_len; $fell(CORE_STALL) |-> stall_r == STALL_CYCLES; endproperty
   a_len: assert property (p_len) else $error("stall length wrong");
   property p_load; NVM_START && NVM_OP == 2'h1 |-> !CORE_STALL [*5]; endproperty
   a_load: assert property (p_load) else $error("load stalled");
   c_erase: cover property (NVM_START && NVM_OP == 2'h0);
   c_pgm: cover property (IND_BUSY);
   c_ref: cover property (CTL_REQ.init_set && key_r != 2'h2);
endmodule
bind pmau_top pmau_props #(.STALL_CYCLES(STALL_CYCLES)) u_props (.*);

// >>> test/pmau_mem_model.sv
`timescale 1ns/1ps
module pmau_mem_model (
   input wire logic        PM_RD_EN, DM_EN,
   input wire logic [14:0] PM_RD_ADDR,
   input wire logic [11:0] DM_ADDR,
   output logic [13:0]     PM_RD_DATA,
   output logic [7:0]      DM_RDATA
);
   // Deselected ports show the inverse so a stale sample cannot pass
   logic [13:0] pw;
   logic [7:0]  dw;
   assign pw = {~PM_RD_ADDR[5:0], PM_RD_ADDR[7:0] ^ 8'h5A};
   assign dw = DM_ADDR[7:0] ^ 8'hC3;
   assign PM_RD_DATA = PM_RD_EN ? pw : ~pw;
   assign DM_RDATA = DM_EN ? dw : ~dw;
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic MCLK = 1'b0, SYS_RST = 1'b1;
   pmau_pkg::pmau_ind_req_t IND_REQ = '0;
   pmau_pkg::pmau_ctl_req_t CTL_REQ = '0;
   logic IND_BUSY, IND_DONE, PM_RD_EN, DM_EN, DM_WE;
   logic NVM_START, FORCE_NOP, CORE_STALL, WR_BUSY;
   logic [7:0] IND_RDATA, DM_WDATA, DM_RDATA;
   logic [14:0] PM_RD_ADDR;
   logic [13:0] PM_RD_DATA;
   logic [11:0] DM_ADDR;
   logic [1:0] NVM_OP;
   int num_errors = 0, num_checks = 0;
   always #12.5 MCLK = ~MCLK;
   pmau_top #(.STALL_CYCLES(5)) uut (.*);
   pmau_mem_model mem (.*);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task results;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task acc(input logic [15:0] p, input logic w, input int cyc, input logic [7:0] exp);
      int n;
      n = 0;
      @(negedge MCLK);
      IND_REQ = '{1'b1, w, p, 8'hA5};
      #1 chk(DM_WE, w & ~p[15]);
      chk(DM_WDATA, 8'hA5);
      while (IND_DONE !== 1'b1) begin
         @(posedge MCLK);
         #1 n++;
         if (n > 8) begin
            num_errors++;
            results();
         end
      end
      chk(n, cyc);
      if (!w) chk(IND_RDATA, exp);
      @(negedge MCLK);
      IND_REQ = '0;
   endtask
   task ctl(input logic k, input logic [7:0] d, input logic i, input logic [1:0] op);
      @(negedge MCLK);
      CTL_REQ = '{k, d, i, pmau_pkg::pmau_op_t'(op)};
      @(negedge MCLK);
      CTL_REQ = '0;
   endtask
   task t_read;
      acc(16'h8123, 1'b0, 2, 8'h23 ^ 8'h5A);
      acc(16'h0FFF, 1'b0, 1, 8'hFF ^ 8'hC3);
      acc(16'h0000, 1'b0, 1, 8'h00 ^ 8'hC3);
      $display("t_read done");
   endtask
   task t_pwrite;
      acc(16'hFFFF, 1'b1, 2, 8'h00);
      acc(16'hFFFF, 1'b0, 2, 8'hFF ^ 8'h5A);
      acc(16'h0010, 1'b1, 1, 8'h00);
      $display("t_pwrite done");
   endtask
   task t_nvm(input logic [1:0] op, input logic good);
      int st, ns, fn, wb;
      st = 0;
      ns = 0;
      fn = 0;
      wb = 0;
      ctl(1'b1, good ? 8'h55 : 8'hAA, 1'b0, op);
      ctl(1'b1, good ? 8'hAA : 8'h55, 1'b0, op);
      ctl(1'b0, 8'h00, 1'b1, op);
      repeat (20) begin
         st += CORE_STALL;
         ns += NVM_START;
         fn += FORCE_NOP;
         wb += WR_BUSY;
         @(negedge MCLK);
      end
      chk(ns, good);
      chk(fn, good ? 2 : 0);
      chk(st, (good && op != 2'h1) ? 5 : 0);
      chk(wb, good ? (pmau_pkg::FORCED_NOPS + ((op != 2'h1) ? 5 : 0)) : 0);
      $display("t_nvm op=%0d good=%0d done", op, good);
   endtask
   initial begin
      repeat (16) @(posedge MCLK);
      @(negedge MCLK) SYS_RST = 1'b0;
      t_read();
      t_pwrite();
      for (int k = 0; k < 4; k++) t_nvm(k[1:0], 1'b1);
      t_nvm(2'h0, 1'b0);
      results();
   end
endmodule
